/* File: rtl/fbwg_top.sv */
// flash bios write glue: decode, strobes, buffer steering, supply latch
//
// The register addresses and the AXI4-Lite register port were decided locally.
module fbwg_top
  import fbwg_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // processor and chipset pins
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic memory_or_io_select,
  input wire logic write_or_read_select,
  input wire logic memory_read_strobe_n,
  input wire logic memory_write_strobe_n,
  input wire logic cpu_data_bit,
  input wire logic sys_reset_n,
  input wire logic logic_supply_ok,
  // flash and buffer pins
  output logic decode_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic wbuf_oe_n,
  output logic periph_rd_en,
  output logic xcvr_dir,
  output logic program_supply_enable
);
  // --- pin synchronisation ---

  // raw pin bundle
  localparam int PIN_W = ADDR_W + 7;
  logic [PIN_W-1:0] pin_raw;
  // synchronised bundle
  logic [PIN_W-1:0] pin_s;
  assign pin_raw = {cpu_addr, memory_or_io_select, write_or_read_select,
                    memory_read_strobe_n, memory_write_strobe_n,
                    cpu_data_bit, sys_reset_n, logic_supply_ok};

  // two flops on every pin before use
  fbwg_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  // unpacked synchronised pins
  wire [ADDR_W-1:0] addr_s = pin_s[PIN_W-1:7];
  wire mem_cyc = pin_s[6];
  wire wr_cyc = pin_s[5];
  wire rd_strobe = !pin_s[4];
  wire wr_strobe = !pin_s[3];
  wire data_s = pin_s[2];
  wire sysrst_s = !pin_s[1];
  wire supply_ok_s = pin_s[0];

  // --- register bus ---

  // register file access
  logic reg_wr;
  logic [7:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic [7:0] reg_raddr;
  logic [31:0] reg_rdata;
  logic reg_rok;
  logic reg_wok;

  // axi4-lite handshake
  fbwg_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_wok(reg_wok),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rok(reg_rok)
  );

  // byte-lane merge of a write into a register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // address range test
  function automatic logic in_range(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] lo,
    input logic [ADDR_W-1:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction

  // software registers
  logic [2:0] ctrl_ff;
  logic [23:0] bios_base_ff;
  logic [23:0] bios_limit_ff;
  logic [15:0] port_addr_ff;
  logic [19:0] seg_cfg_ff;
  logic [15:0] wr_count_ff;

  // write decode
  wire wr_ctrl = reg_wr && (reg_waddr == OFS_CTRL);
  wire wr_base = reg_wr && (reg_waddr == OFS_BIOS_BASE);
  wire wr_limit = reg_wr && (reg_waddr == OFS_BIOS_LIMIT);
  wire wr_port = reg_wr && (reg_waddr == OFS_PORT_ADDR);
  wire wr_seg = reg_wr && (reg_waddr == OFS_SEG_CFG);
  wire wr_cnt = reg_wr && (reg_waddr == OFS_WR_COUNT);
  wire wr_stat = reg_wr && (reg_waddr == OFS_STATUS);
  assign reg_wok = wr_ctrl || wr_base || wr_limit || wr_port ||
                   wr_seg || wr_cnt || wr_stat;

  // merged write values
  wire [31:0] ctrl_m = lane_merge({29'h0, ctrl_ff}, reg_wdata, reg_wstrb);
  wire [31:0] base_m = lane_merge({8'h00, bios_base_ff}, reg_wdata, reg_wstrb);
  wire [31:0] lim_m = lane_merge({8'h00, bios_limit_ff}, reg_wdata, reg_wstrb);
  wire [31:0] port_m = lane_merge({16'h0000, port_addr_ff}, reg_wdata, reg_wstrb);
  wire [31:0] seg_m = lane_merge({12'h000, seg_cfg_ff}, reg_wdata, reg_wstrb);

  // control fields
  wire write_allow = ctrl_ff[CTRL_WRITE_ALLOW];
  wire shadow_off = ctrl_ff[CTRL_SHADOW_OFF];
  wire settle_gate = ctrl_ff[CTRL_SETTLE_GATE];
  wire [7:0] e_seg_cfg = seg_cfg_ff[SEG_E_LSB +: 8];
  wire [7:0] f_seg_cfg = seg_cfg_ff[SEG_F_LSB +: 8];
  wire [3:0] page_active = seg_cfg_ff[SEG_PAGE_LSB +: 4];

  // configuration register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      bios_base_ff <= BIOS_BASE_RST;
      bios_limit_ff <= BIOS_LIMIT_RST;
      port_addr_ff <= PORT_ADDR_RST;
      seg_cfg_ff <= SEG_CFG_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= ctrl_m[2:0];
      if (wr_base) bios_base_ff <= base_m[23:0];
      if (wr_limit) bios_limit_ff <= lim_m[23:0];
      if (wr_port) port_addr_ff <= port_m[15:0];
      if (wr_seg) seg_cfg_ff <= seg_m[19:0];
    end
  end

  // --- address decode ---

  // address inside the programmed bios range
  wire bios_hit = in_range(addr_s, bios_base_ff, bios_limit_ff);
  // top segment range, kept selected when shadow is off
  wire f_hit = in_range(addr_s, F_SEG_BASE, F_SEG_TOP);
  // expanded paging segment
  wire e_hit = in_range(addr_s, E_SEG_BASE, F_SEG_BASE - 24'h00_0001);
  // 16 K window index inside the e segment
  wire [1:0] page_idx = addr_s[15:14];
  // window taken over by an active paging register
  wire page_block = e_hit && page_active[page_idx];
  // segments only open when both access configs are zero
  wire seg_open = (e_seg_cfg == 8'h00) && (f_seg_cfg == 8'h00);
  // shadowed part dropped, top segment kept
  wire shadow_ok = !shadow_off || f_hit;
  // full select condition for the flash
  wire sel_hit = bios_hit && seg_open && shadow_ok && !page_block;

  // decoder low for memory, write and range together
  wire dec_hit = mem_cyc && wr_cyc && sel_hit;

  // --- supply enable latch ---

  // io write to the supply port address
  wire port_hit = !mem_cyc && wr_cyc && (addr_s[15:0] == port_addr_ff);
  // both active-low terms low: or-clock is low
  wire latch_clk_low = port_hit && wr_strobe;
  // forced-off conditions
  wire supply_kill = sysrst_s || !supply_ok_s;

  // or-clock low last cycle
  logic clk_low_ff;
  // data bit held while the or-clock is low
  logic data_hold_ff;
  // the latch itself
  logic latch_ff;
  // settle counter and done flag
  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt_ff;
  logic settled_ff;

  // rising edge of the or-clock ends the write
  wire latch_edge = clk_low_ff && !latch_clk_low;
  // next latch state
  wire nxt_latch = supply_kill ? 1'b0 :
                   latch_edge ? data_hold_ff : latch_ff;

  // latch with capture on the strobe end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_low_ff <= 1'b0;
      data_hold_ff <= 1'b0;
      latch_ff <= 1'b0;
    end else begin
      clk_low_ff <= latch_clk_low;
      if (latch_clk_low) data_hold_ff <= data_s;
      latch_ff <= nxt_latch;
    end
  end

  // settle timer restarts whenever the supply is off
  wire settle_done = (settle_cnt_ff == SETTLE_CYCLES[$bits(settle_cnt_ff)-1:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn || !latch_ff) begin
      settle_cnt_ff <= '0;
      settled_ff <= 1'b0;
    end else if (!settle_done) begin
      settle_cnt_ff <= settle_cnt_ff + 1'b1;
    end else begin
      settled_ff <= 1'b1;
    end
  end

  // --- flash strobes and buffers ---

  // writes allowed only with logic supply good and software consent
  wire we_gate = write_allow && supply_ok_s &&
                 (settled_ff || !settle_gate);
  // write enable: processor write with decoder output
  wire we_hit = dec_hit && wr_strobe && we_gate;
  // read cycle in range
  wire rd_hit = mem_cyc && !wr_cyc && sel_hit && rd_strobe;

  // next pin values
  wire nxt_decode_n = !dec_hit;
  wire nxt_ce_n = !(dec_hit || rd_hit);
  wire nxt_we_n = !(we_hit && mem_cyc && wr_cyc);
  wire nxt_oe_n = !rd_hit;
  wire nxt_wbuf_oe_n = !dec_hit;
  wire nxt_dir = dec_hit;
  wire nxt_supply = latch_ff && !sysrst_s;

  // registered flash and buffer pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decode_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      wbuf_oe_n <= 1'b1;
      periph_rd_en <= 1'b0;
      xcvr_dir <= 1'b0;
      program_supply_enable <= 1'b0;
    end else begin
      decode_n <= nxt_decode_n;
      flash_ce_n <= nxt_ce_n;
      flash_we_n <= nxt_we_n;
      flash_oe_n <= nxt_oe_n;
      wbuf_oe_n <= nxt_wbuf_oe_n;
      periph_rd_en <= rd_hit;
      xcvr_dir <= nxt_dir;
      program_supply_enable <= nxt_supply;
    end
  end

  // --- write counter ---

  // previous write enable, for one count per strobe
  logic we_prev_ff;
  wire we_start = we_hit && !we_prev_ff;
  // counts flash write strobes; software write clears, a new strobe wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      we_prev_ff <= 1'b0;
      wr_count_ff <= 16'h0000;
    end else begin
      we_prev_ff <= we_hit;
      if (we_start) wr_count_ff <= wr_cnt ? 16'h0001 : wr_count_ff + 16'h0001;
      else if (wr_cnt) wr_count_ff <= 16'h0000;
    end
  end

  // --- read mux ---

  // live status word
  wire [31:0] status_w = {28'h000_0000, sysrst_s, !supply_ok_s,
                          settled_ff, latch_ff};
  // read decode
  wire rd_ctrl = (reg_raddr == OFS_CTRL);
  wire rd_base = (reg_raddr == OFS_BIOS_BASE);
  wire rd_limit = (reg_raddr == OFS_BIOS_LIMIT);
  wire rd_port = (reg_raddr == OFS_PORT_ADDR);
  wire rd_seg = (reg_raddr == OFS_SEG_CFG);
  wire rd_stat = (reg_raddr == OFS_STATUS);
  wire rd_cnt = (reg_raddr == OFS_WR_COUNT);
  assign reg_rok = rd_ctrl || rd_base || rd_limit || rd_port ||
                   rd_seg || rd_stat || rd_cnt;
  // selected read word, zero when unmapped
  assign reg_rdata = rd_ctrl ? {29'h0, ctrl_ff} :
                     rd_base ? {8'h00, bios_base_ff} :
                     rd_limit ? {8'h00, bios_limit_ff} :
                     rd_port ? {16'h0000, port_addr_ff} :
                     rd_seg ? {12'h000, seg_cfg_ff} :
                     rd_stat ? status_w :
                     rd_cnt ? {16'h0000, wr_count_ff} :
                     32'h0000_0000;
endmodule // fbwg_top

/* File: inc/fbwg_pkg.sv */
// package: constants, offsets and reset values of the flash bios write glue
package fbwg_pkg;
  // processor address width
  localparam int ADDR_W = 24;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BIOS_BASE = 8'h04;
  localparam logic [7:0] OFS_BIOS_LIMIT = 8'h08;
  localparam logic [7:0] OFS_PORT_ADDR = 8'h0c;
  localparam logic [7:0] OFS_SEG_CFG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_WR_COUNT = 8'h18;
  // control bit positions
  localparam int CTRL_WRITE_ALLOW = 0;
  localparam int CTRL_SHADOW_OFF = 1;
  localparam int CTRL_SETTLE_GATE = 2;
  // segment config field positions
  localparam int SEG_E_LSB = 0;
  localparam int SEG_F_LSB = 8;
  localparam int SEG_PAGE_LSB = 16;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [23:0] BIOS_BASE_RST = 24'h0e_0000;
  localparam logic [23:0] BIOS_LIMIT_RST = 24'h0f_ffff;
  localparam logic [15:0] PORT_ADDR_RST = 16'h00f0;
  localparam logic [19:0] SEG_CFG_RST = 20'h0_0000;
  // segment bounds
  localparam logic [23:0] E_SEG_BASE = 24'h0e_0000;
  localparam logic [23:0] F_SEG_BASE = 24'h0f_0000;
  localparam logic [23:0] F_SEG_TOP = 24'h0f_ffff;
  // supply settle time and clock rate
  localparam int SETTLE_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/fbwg_sync.sv */
// two flip-flop synchroniser for pin inputs
module fbwg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read only by the second
  logic [WIDTH-1:0] meta_ff;
  // two stages, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // fbwg_sync

/* File: rtl/fbwg_axil.sv */
// axi4-lite slave handshake, hands single accesses to the register file
module fbwg_axil
  import fbwg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic reg_wr,
  output logic [7:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic [7:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);
  // held address and data flags
  logic aw_ff;
  logic w_ff;
  // held write address, data and strobes
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  // channel takes
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire ar_take = s_arvalid && s_arready;
  // both halves present, write fires
  wire wr_go = (aw_ff || aw_take) && (w_ff || w_take) && !s_bvalid;
  assign reg_wr = wr_go;
  assign reg_raddr = s_araddr;
  // a half taken on the firing edge bypasses its holding flops
  assign reg_waddr = aw_take ? s_awaddr : awaddr_ff;
  assign reg_wdata = w_take ? s_wdata : wdata_ff;
  assign reg_wstrb = w_take ? s_wstrb : wstrb_ff;
  // ready while nothing held and no response pending
  assign s_awready = !aw_ff && !s_bvalid;
  assign s_wready = !w_ff && !s_bvalid;
  assign s_arready = !s_rvalid;
  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) awaddr_ff <= s_awaddr;
      if (w_take) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      aw_ff <= wr_go ? 1'b0 : (aw_ff || aw_take);
      w_ff <= wr_go ? 1'b0 : (w_ff || w_take);
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= reg_wok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // read channel, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_rvalid <= 1'b1;
      s_rdata <= reg_rdata;
      s_rresp <= reg_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule // fbwg_axil

/* File: test/fbwg_top_properties.sv */
// checker: pin-side and bus-side properties of the flash bios write glue
module fbwg_chk
  import fbwg_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic memory_or_io_select,
  input wire logic sys_reset_n,
  input wire logic logic_supply_ok,
  input wire logic decode_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic wbuf_oe_n,
  input wire logic periph_rd_en,
  input wire logic xcvr_dir,
  input wire logic program_supply_enable
);
  // one domain: common clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_we_in_decode: assert property (!flash_we_n |-> !decode_n)
    else $error("write enable low outside decode");
  a_we_not_read: assert property (!flash_we_n |-> flash_oe_n)
    else $error("write enable with output enable");
  a_io_no_write: assert property (!memory_or_io_select [*4] |=> flash_we_n && decode_n)
    else $error("write enable in io cycle");
  a_oe_with_ce: assert property (!flash_oe_n |-> !flash_ce_n && periph_rd_en)
    else $error("read without chip enable or read path");
  a_wbuf_decode: assert property (wbuf_oe_n == decode_n)
    else $error("write buffer not tied to decode");
  a_dir_to_flash: assert property (!decode_n |-> xcvr_dir && flash_oe_n)
    else $error("transceiver direction wrong on write");
  a_warm_reset_off: assert property (!sys_reset_n [*4] |=> !program_supply_enable)
    else $error("supply on during system reset");
  a_low_supply_off: assert property (!logic_supply_ok [*4] |=> !program_supply_enable && flash_we_n)
    else $error("supply or write on with low logic supply");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  // main scenarios reached
  c_flash_write: cover property (!flash_we_n);
  c_flash_read: cover property (!flash_oe_n);
  c_supply_on: cover property ($rose(program_supply_enable));
endmodule // fbwg_chk

bind fbwg_top fbwg_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .memory_or_io_select(memory_or_io_select), .sys_reset_n(sys_reset_n),
  .logic_supply_ok(logic_supply_ok), .decode_n(decode_n), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .wbuf_oe_n(wbuf_oe_n),
  .periph_rd_en(periph_rd_en), .xcvr_dir(xcvr_dir),
  .program_supply_enable(program_supply_enable));

/* File: test/fbwg_flash_model.sv */
// flash device model: command lockout and command counting
module fbwg_flash_model (
  input wire logic aclk,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic program_supply_enable,
  input wire logic logic_supply_ok,
  output logic [7:0] cmd_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic we_q = 1'b1; // last write enable level
  logic powered; // both supplies past lockout
  assign powered = program_supply_enable && logic_supply_ok;
  initial cmd_count = 8'h00;
  // a command is taken at each write strobe start, only while powered
  always @(posedge aclk) begin
    we_q <= flash_we_n;
    if (we_q && !flash_we_n && !flash_ce_n && powered) begin
      cmd_count <= cmd_count + 8'h01;
    end
  end
endmodule // fbwg_flash_model

/* File: test/fbwg_tb_top.sv */
// testbench: register bus, supply latch, flash strobes and range decode
`define FBWG_CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module fbwg_tb_top
  import fbwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000, s_rdata;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [23:0] cpu_addr = 24'h00_0000; // processor pins, idle read of memory
  logic memory_or_io_select = 1'b1, write_or_read_select = 1'b0, cpu_data_bit = 1'b0;
  logic memory_read_strobe_n = 1'b1, memory_write_strobe_n = 1'b1;
  logic sys_reset_n = 1'b1, logic_supply_ok = 1'b1;
  logic decode_n, flash_ce_n, flash_we_n, flash_oe_n, wbuf_oe_n, periph_rd_en, xcvr_dir;
  logic program_supply_enable;
  logic [7:0] cmd_count; // commands taken by the flash model
  int miscompares = 0, checks = 0;
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // short settle count keeps the run brief
  fbwg_top #(.SETTLE_CYCLES(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .cpu_addr(cpu_addr), .memory_or_io_select(memory_or_io_select),
    .write_or_read_select(write_or_read_select), .memory_read_strobe_n(memory_read_strobe_n),
    .memory_write_strobe_n(memory_write_strobe_n), .cpu_data_bit(cpu_data_bit),
    .sys_reset_n(sys_reset_n), .logic_supply_ok(logic_supply_ok), .decode_n(decode_n),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .wbuf_oe_n(wbuf_oe_n), .periph_rd_en(periph_rd_en), .xcvr_dir(xcvr_dir),
    .program_supply_enable(program_supply_enable));
  fbwg_flash_model u_flash (.aclk(aclk), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .program_supply_enable(program_supply_enable), .logic_supply_ok(logic_supply_ok),
    .cmd_count(cmd_count));
  // counts, verdict, end of run
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // handshake bound used up
  task automatic tmo(input int n);
    if (n >= 64) begin
      miscompares++;
      $display("ERROR handshake expected done seen timeout");
      final_report();
    end
  endtask
  // single write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    tmo(n);
    `FBWG_CHK("bresp", er, s_bresp)
  endtask
  // single read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s_rready <= 1'b0;
    tmo(n);
    `FBWG_CHK("rresp", er, s_rresp)
    `FBWG_CHK("rdata", ed, s_rdata)
  endtask
  // set processor pins, then let the three-clock lag pass
  task automatic pin(input logic [23:0] a, input logic m, input logic w, input logic rn,
                     input logic wn);
    @(posedge aclk);
    cpu_addr <= a;
    memory_or_io_select <= m;
    write_or_read_select <= w;
    memory_read_strobe_n <= rn;
    memory_write_strobe_n <= wn;
    repeat (5) @(posedge aclk);
  endtask
  // io write of one data bit to the supply port
  task automatic sup(input logic v);
    cpu_data_bit <= v;
    pin(24'h00_00f0, 1'b0, 1'b1, 1'b1, 1'b0);
    pin(24'h00_00f0, 1'b0, 1'b1, 1'b1, 1'b1);
    `FBWG_CHK("supply", v, program_supply_enable)
  endtask
  // reset values, field width, unmapped offset
  task automatic t_regs;
    rdc(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rdc(OFS_BIOS_BASE, 32'h000e_0000, RESP_OKAY);
    rdc(OFS_BIOS_LIMIT, 32'h000f_ffff, RESP_OKAY);
    rdc(OFS_PORT_ADDR, 32'h0000_00f0, RESP_OKAY);
    rdc(OFS_SEG_CFG, 32'h0000_0000, RESP_OKAY);
    rdc(8'h1c, 32'h0000_0000, RESP_SLVERR);
    wr(8'h1c, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_PORT_ADDR, 32'hffff_00f0, RESP_OKAY);
    rdc(OFS_PORT_ADDR, 32'h0000_00f0, RESP_OKAY);
    $display("test regs done");
  endtask
  // supply latch on, off, warm reset, low logic supply, settle flag
  task automatic t_supply;
    sup(1'b1);
    sup(1'b0);
    sup(1'b1);
    sys_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    `FBWG_CHK("supply_reset", 1'b0, program_supply_enable)
    sys_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
    `FBWG_CHK("supply_after_reset", 1'b0, program_supply_enable)
    sup(1'b1);
    logic_supply_ok <= 1'b0;
    repeat (6) @(posedge aclk);
    `FBWG_CHK("supply_low", 1'b0, program_supply_enable)
    logic_supply_ok <= 1'b1;
    sup(1'b1);
    repeat (10) @(posedge aclk);
    rdc(OFS_STATUS, 32'h0000_0003, RESP_OKAY);
    $display("test supply done");
  endtask
  // flash write and read strobes, io and out-of-range cycles
  task automatic t_write;
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("decode_n", 1'b0, decode_n)
    `FBWG_CHK("we_blocked", 1'b1, flash_we_n)
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFS_WR_COUNT, 32'h0000_0000, RESP_OKAY);
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("we_n", 1'b0, flash_we_n)
    `FBWG_CHK("ce_n", 1'b0, flash_ce_n)
    `FBWG_CHK("wbuf_oe_n", 1'b0, wbuf_oe_n)
    `FBWG_CHK("dir", 1'b1, xcvr_dir)
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b1);
    `FBWG_CHK("we_end", 1'b1, flash_we_n)
    `FBWG_CHK("cmd_count", 8'h01, cmd_count)
    rdc(OFS_WR_COUNT, 32'h0000_0001, RESP_OKAY);
    pin(24'h0f_0000, 1'b1, 1'b0, 1'b0, 1'b1);
    `FBWG_CHK("oe_n", 1'b0, flash_oe_n)
    `FBWG_CHK("periph_rd", 1'b1, periph_rd_en)
    `FBWG_CHK("we_read", 1'b1, flash_we_n)
    `FBWG_CHK("dir_read", 1'b0, xcvr_dir)
    pin(24'h0f_0000, 1'b0, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("we_io", 1'b1, flash_we_n)
    `FBWG_CHK("decode_io", 1'b1, decode_n)
    pin(24'h10_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("decode_out", 1'b1, decode_n)
    pin(24'h10_0000, 1'b1, 1'b0, 1'b1, 1'b1);
    $display("test write done");
  endtask
  // shadow off, segment access and paging windows
  task automatic t_map;
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("shadow_e", 1'b1, decode_n)
    pin(24'h0f_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("shadow_f", 1'b0, decode_n)
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(OFS_SEG_CFG, 32'h0000_0100, RESP_OKAY);
    pin(24'h0f_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("seg_f", 1'b1, decode_n)
    wr(OFS_SEG_CFG, 32'h0002_0000, RESP_OKAY);
    pin(24'h0e_4000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("page_on", 1'b1, decode_n)
    pin(24'h0e_8000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("page_off", 1'b0, decode_n)
    pin(24'h0e_8000, 1'b1, 1'b0, 1'b1, 1'b1);
    wr(OFS_SEG_CFG, 32'h0000_0000, RESP_OKAY);
    $display("test map done");
  endtask
  // write enable held back until the supply has settled
  task automatic t_settle;
    wr(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    sup(1'b0);
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("we_unsettled", 1'b1, flash_we_n)
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b1);
    sup(1'b1);
    repeat (12) @(posedge aclk);
    pin(24'h0e_0000, 1'b1, 1'b1, 1'b1, 1'b0);
    `FBWG_CHK("we_settled", 1'b0, flash_we_n)
    pin(24'h0e_0000, 1'b1, 1'b0, 1'b1, 1'b1);
    $display("test settle done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_supply();
    t_write();
    t_map();
    t_settle();
    final_report();
  end
  // whole-run watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("ERROR run expected done seen timeout");
    final_report();
  end
endmodule // fbwg_tb_top
